// File: tetc_defines.vh
// Constants for the trap and wait control block: offsets, fields, reset values.
// Assumes a 32-bit hart with M, S and U privilege and a 20 MHz core clock.
`ifndef TETC_DEFINES_VH
`define TETC_DEFINES_VH
// ----------------------------------------------------------------
// Privilege encodings
// ----------------------------------------------------------------
`define TETC_PRV_U        2'h0
`define TETC_PRV_S        2'h1
`define TETC_PRV_M        2'h3
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define TETC_OFF_STVEC    8'h00
`define TETC_OFF_SEPC     8'h04
`define TETC_OFF_SCAUSE   8'h08
`define TETC_OFF_STVAL    8'h0c
`define TETC_OFF_SSTATUS  8'h10
`define TETC_OFF_MEDELEG  8'h14
`define TETC_OFF_MSTATUS  8'h18
`define TETC_OFF_STATE    8'h1c
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TETC_SIE_BIT      1
`define TETC_SPIE_BIT     5
`define TETC_MIE_BIT      3
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TETC_RST_SSTATUS  32'h00000020
`define TETC_RST_WORD     32'h00000000
`define TETC_RST_PRV      2'h3
`endif

// File: tetc_trap_ctl.v
// Trap decision, supervisor trap entry/return and low-power wake control of one hart.
// Assumes exception, interrupt and wait requests come from core logic on clk; the
// interrupt arbiter presents its winner with mode, level and priority already packed.
`timescale 1ns/1ps
`include "tetc_defines.vh"

// Functional notes
// RULE1 - A winning machine interrupt may pre-empt a running supervisor handler.
// RULE2 - A supervisor interrupt never pre-empts a machine interrupt handler.
// RULE3 - In machine mode a pending supervisor interrupt is not taken.
// RULE4 - Exceptions go to supervisor only from user, or supervisor with delegation set.
// RULE5 - Exceptions raised in machine mode always stay in machine mode.
// RULE6 - Exceptions are never masked; each is taken in machine or supervisor. The code ignores exceptions while sleep_r is set.
// RULE7 - Among same-target exceptions the smallest code is taken first.
// RULE8 - Simultaneous supervisor and machine targeted exceptions: machine wins.
// RULE9 - Supervisor exception entry jumps to stvec and writes the cause.
// RULE10 - Supervisor exception entry saves faulting pc and fault value.
// RULE11 - Supervisor entry copies enable into previous enable, then clears enable.
// RULE12 - Supervisor return resumes at the saved exception pc.
// RULE13 - Supervisor return restores enable from previous, then sets previous.
// RULE14 - Software avoids nesting supervisor exceptions inside a supervisor handler.
// RULE15 - Machine traps and NMI leave supervisor trap registers untouched.
// RULE16 - User wait: any winning interrupt wakes and traps, ignoring enables.
// RULE17 - Supervisor wait: supervisor interrupt traps or resumes per enable; machine always traps.
// RULE18 - Machine wait excludes supervisor interrupts, so hart keeps sleeping.
// RULE19 - Machine wait: machine interrupt wakes, traps or resumes per machine enable.
// RULE20 - NMI or debug request wakes the hart from any wait.
// RULE21 - Wait with event select sleeps until event, NMI or debug only.
// RULE22 - Arbitration ranks by mode, then level, then priority, largest wins.
// RULE23 - Exceptions without fault value write zero into the fault value register.
module tetc_trap_ctl (
  clk,
  sys_rst,
  wb_cyc_i,
  wb_stb_i,
  wb_we_i,
  wb_adr_i,
  wb_sel_i,
  wb_dat_i,
  wb_dat_o,
  wb_ack_o,
  cur_pc,
  exc_vec,
  exc_tval,
  exc_tval_vld,
  sret_req,
  mret_req,
  mret_prv,
  irq_vld,
  irq_key,
  irq_id,
  irq_active_m,
  nmi_req,
  dbg_req,
  wfi_req,
  wfe_sel,
  event_req,
  trap_take,
  trap_to_s,
  trap_cause,
  trap_is_irq,
  pc_redir,
  pc_target,
  sleeping,
  wake,
  prv_mode
);
  input  wire        clk;
  input  wire        sys_rst;
  input  wire        wb_cyc_i;
  input  wire        wb_stb_i;
  input  wire        wb_we_i;
  input  wire [7:0]  wb_adr_i;
  input  wire [3:0]  wb_sel_i;
  input  wire [31:0] wb_dat_i;
  output reg  [31:0] wb_dat_o;
  output reg         wb_ack_o;
  input  wire [31:0] cur_pc;
  input  wire [15:0] exc_vec;
  input  wire [31:0] exc_tval;
  input  wire        exc_tval_vld;
  input  wire        sret_req;
  input  wire        mret_req;
  input  wire [1:0]  mret_prv;
  input  wire [15:0] irq_vld;
  input  wire [15:0] irq_key;
  input  wire [7:0]  irq_id;
  input  wire        irq_active_m;
  input  wire        nmi_req;
  input  wire        dbg_req;
  input  wire        wfi_req;
  input  wire        wfe_sel;
  input  wire        event_req;
  output reg         trap_take;
  output reg         trap_to_s;
  output reg  [31:0] trap_cause;
  output reg         trap_is_irq;
  output reg         pc_redir;
  output reg  [31:0] pc_target;
  output reg         sleeping;
  output reg         wake;
  output reg  [1:0]  prv_mode;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Lowest set index of a pending vector
  function [4:0] lowest_code;
    input [15:0] v;
    integer k;
    begin
      lowest_code = 5'h10;
      for (k = 15; k >= 0; k = k - 1) begin
        if (v[k]) begin
          lowest_code = k[4:0];
        end
      end
    end
  endfunction

  // Byte-lane merge for Wishbone writes
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer k;
    begin
      merge = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          merge[k*8 +: 8] = new_v[k*8 +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [31:0] stvec_r;
  reg [31:0] sepc_r;
  reg [31:0] scause_r;
  reg [31:0] stval_r;
  reg [31:0] sstatus_r;
  reg [31:0] medeleg_r;
  reg [31:0] mstatus_r;
  reg [1:0]  prv_r;
  reg        sleep_r;
  reg        sleep_wfe_r;
  reg [1:0]  sleep_prv_r;
  reg        s_active_r;

  // ----------------------------------------------------------------
  // Interrupt arbitration
  // ----------------------------------------------------------------
  // Key is {mode, level, priority}; mode in the top two bits
  reg  [15:0] win_key;
  reg         win_vld;
  integer     i;
  always @* begin
    win_key = 16'h0000;
    win_vld = 1'b0;
    for (i = 0; i < 16; i = i + 1) begin
      // Unsigned compare of the packed key gives mode over level over priority
      if (irq_vld[i] && (!win_vld || irq_key > win_key)) begin // [RULE22]
        win_key = irq_key;
        win_vld = 1'b1;
      end
    end
  end

  wire irq_m = win_vld && (win_key[15:14] == `TETC_PRV_M);
  // Supervisor interrupts drop out entirely in machine mode
  wire irq_s = win_vld && (win_key[15:14] == `TETC_PRV_S) && (prv_r != `TETC_PRV_M)
               && !irq_active_m; // [RULE2] [RULE3] [RULE18]
  wire sie   = sstatus_r[`TETC_SIE_BIT];
  wire mie   = mstatus_r[`TETC_MIE_BIT];

  // ----------------------------------------------------------------
  // Exception target and priority
  // ----------------------------------------------------------------
  // Machine mode ignores delegation; user mode delegates everything
  wire [15:0] exc_s = (prv_r == `TETC_PRV_M) ? 16'h0000 :
                      (prv_r == `TETC_PRV_U) ? exc_vec :
                      (exc_vec & medeleg_r[15:0]); // [RULE4] [RULE5]
  wire [15:0] exc_m = exc_vec & ~exc_s;
  wire        exc_any = |exc_vec; // [RULE6]
  wire        exc_go_m = |exc_m; // [RULE8]
  wire [4:0]  exc_code = exc_go_m ? lowest_code(exc_m) : lowest_code(exc_s); // [RULE7]

  // ----------------------------------------------------------------
  // Wake and take decision
  // ----------------------------------------------------------------
  reg wake_c;
  reg take_irq_m;
  reg take_irq_s;
  always @* begin
    wake_c = 1'b0;
    take_irq_m = 1'b0;
    take_irq_s = 1'b0;
    if (sleep_r) begin
      if (nmi_req || dbg_req) begin
        wake_c = 1'b1; // [RULE20]
      end
      if (sleep_wfe_r) begin
        wake_c = wake_c | event_req; // [RULE21]
      end else begin
        case (sleep_prv_r)
          `TETC_PRV_U: begin
            wake_c = wake_c | irq_m | irq_s;
            take_irq_m = irq_m; // [RULE16]
            take_irq_s = irq_s && !irq_m;
          end
          `TETC_PRV_S: begin
            wake_c = wake_c | irq_m | irq_s;
            take_irq_m = irq_m; // [RULE17]
            take_irq_s = irq_s && !irq_m && sie;
          end
          default: begin
            wake_c = wake_c | irq_m; // [RULE18] [RULE19]
            take_irq_m = irq_m && mie;
          end
        endcase
      end
    end else begin
      // Machine interrupts may pre-empt a supervisor handler
      take_irq_m = irq_m && (mie || prv_r != `TETC_PRV_M); // [RULE1]
      take_irq_s = irq_s && !irq_m && (sie || prv_r == `TETC_PRV_U);
    end
  end

  wire go_exc_s = !sleep_r && exc_any && !exc_go_m && !nmi_req;
  wire go_m     = (!sleep_r && (exc_go_m || nmi_req)) || take_irq_m;
  wire go_irq_s = take_irq_s && !go_m && !(exc_any && !sleep_r);
  // A machine trap in the same cycle owns the entry, so no supervisor flags may leak out
  wire go_s     = (go_exc_s || go_irq_s) && !go_m;

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wb_wr  = wb_req && wb_we_i;
  reg  [31:0] rd_c;
  always @* begin
    case (wb_adr_i)
      `TETC_OFF_STVEC:   rd_c = stvec_r;
      `TETC_OFF_SEPC:    rd_c = sepc_r;
      `TETC_OFF_SCAUSE:  rd_c = scause_r;
      `TETC_OFF_STVAL:   rd_c = stval_r;
      `TETC_OFF_SSTATUS: rd_c = sstatus_r;
      `TETC_OFF_MEDELEG: rd_c = medeleg_r;
      `TETC_OFF_MSTATUS: rd_c = mstatus_r;
      `TETC_OFF_STATE:   rd_c = {27'h0000000, s_active_r, sleep_wfe_r, sleep_r, prv_r};
      default:           rd_c = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequential
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      stvec_r     <= `TETC_RST_WORD;
      sepc_r      <= `TETC_RST_WORD;
      scause_r    <= `TETC_RST_WORD;
      stval_r     <= `TETC_RST_WORD;
      sstatus_r   <= `TETC_RST_SSTATUS;
      medeleg_r   <= `TETC_RST_WORD;
      mstatus_r   <= `TETC_RST_WORD;
      prv_r       <= `TETC_RST_PRV;
      sleep_r     <= 1'b0;
      sleep_wfe_r <= 1'b0;
      sleep_prv_r <= `TETC_RST_PRV;
      s_active_r  <= 1'b0;
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h00000000;
      trap_take   <= 1'b0;
      trap_to_s   <= 1'b0;
      trap_cause  <= 32'h00000000;
      trap_is_irq <= 1'b0;
      pc_redir    <= 1'b0;
      pc_target   <= 32'h00000000;
      wake        <= 1'b0;
    end else begin
      wb_ack_o    <= wb_req;
      wb_dat_o    <= wb_req ? rd_c : 32'h00000000;
      trap_take   <= go_m || go_s;
      trap_to_s   <= go_s;
      trap_is_irq <= go_irq_s || (take_irq_m && !(exc_any && !sleep_r) && !nmi_req);
      pc_redir    <= go_s || (sret_req && !go_m);
      wake        <= wake_c;
      if (wb_wr) begin
        case (wb_adr_i)
          `TETC_OFF_STVEC:   stvec_r   <= merge(stvec_r, wb_dat_i, wb_sel_i);
          `TETC_OFF_SEPC:    sepc_r    <= merge(sepc_r, wb_dat_i, wb_sel_i);
          `TETC_OFF_SCAUSE:  scause_r  <= merge(scause_r, wb_dat_i, wb_sel_i);
          `TETC_OFF_STVAL:   stval_r   <= merge(stval_r, wb_dat_i, wb_sel_i);
          `TETC_OFF_SSTATUS: sstatus_r <= merge(sstatus_r, wb_dat_i, wb_sel_i);
          `TETC_OFF_MEDELEG: medeleg_r <= merge(medeleg_r, wb_dat_i, wb_sel_i);
          `TETC_OFF_MSTATUS: mstatus_r <= merge(mstatus_r, wb_dat_i, wb_sel_i);
          default: begin
          end
        endcase
      end
      // Hardware updates come after software writes so a trap in the same cycle wins
      if (wake_c) begin
        sleep_r <= 1'b0;
      end else if (wfi_req && !sleep_r && !go_m && !go_s) begin
        sleep_r     <= 1'b1;
        sleep_wfe_r <= wfe_sel; // [RULE21]
        sleep_prv_r <= prv_r;
      end
      if (go_m) begin
        // Supervisor trap registers deliberately left alone
        prv_r      <= `TETC_PRV_M; // [RULE15]
        trap_cause <= nmi_req ? 32'h00000000 : take_irq_m && !exc_any ? {24'h000000, irq_id}
                      : {27'h0000000, exc_code};
      end else if (go_s) begin
        pc_target  <= stvec_r; // [RULE9]
        scause_r   <= go_irq_s ? {1'b1, 23'h000000, irq_id} : {27'h0000000, exc_code}; // [RULE9]
        trap_cause <= go_irq_s ? {1'b1, 23'h000000, irq_id} : {27'h0000000, exc_code};
        sepc_r     <= cur_pc; // [RULE10]
        // Nested supervisor exception here is software's fault and is not guarded
        stval_r    <= (go_exc_s && exc_tval_vld) ? exc_tval : 32'h00000000; // [RULE10] [RULE23] [RULE14]
        sstatus_r[`TETC_SPIE_BIT] <= sie; // [RULE11]
        sstatus_r[`TETC_SIE_BIT]  <= 1'b0; // [RULE11]
        prv_r      <= `TETC_PRV_S;
        s_active_r <= 1'b1;
      end else if (sret_req) begin
        pc_target  <= sepc_r; // [RULE12]
        sstatus_r[`TETC_SIE_BIT]  <= sstatus_r[`TETC_SPIE_BIT]; // [RULE13]
        sstatus_r[`TETC_SPIE_BIT] <= 1'b1; // [RULE13]
        prv_r      <= `TETC_PRV_U;
        s_active_r <= 1'b0;
      end else if (mret_req) begin
        prv_r <= mret_prv;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always @* begin
    sleeping = sleep_r;
    prv_mode = prv_r;
  end
endmodule // tetc_trap_ctl

// File: tetc_trap_chk_assertions.sv
// Checker for the trap and wait control block, bound to its top module.
// Assumes sys_rst is synchronous, active high, on clk.
`timescale 1ns/1ps
`include "tetc_defines.vh"
module tetc_trap_chk (
  input wire        clk,
  input wire        sys_rst,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire [15:0] exc_vec,
  input wire [15:0] irq_vld,
  input wire        nmi_req,
  input wire        sret_req,
  input wire        mret_req,
  input wire        irq_active_m,
  input wire        trap_take,
  input wire        trap_to_s,
  input wire        trap_is_irq,
  input wire        pc_redir,
  input wire        sleeping,
  input wire [1:0]  prv_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answers_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_m_exc_stays: assert property (prv_mode == `TETC_PRV_M |=> !(trap_take && trap_to_s))
    else $error("trap from machine mode went to supervisor");
  a_exc_not_masked: assert property (exc_vec != 16'h0 |=> trap_take)
    else $error("exception not taken");
  a_m_not_preempted: assert property (irq_active_m |=> !(trap_take && trap_to_s && trap_is_irq))
    else $error("supervisor interrupt pre-empted machine handler");
  a_u_exc_to_s: assert property (prv_mode == `TETC_PRV_U && exc_vec != 16'h0 && !nmi_req && irq_vld == 16'h0
    && !sret_req && !mret_req |=> trap_take && trap_to_s)
    else $error("user exception not taken in supervisor");
  a_s_trap_redir: assert property (trap_take && trap_to_s |-> pc_redir)
    else $error("supervisor trap without redirect");
  a_m_trap_quiet: assert property (trap_take && !trap_to_s |-> !pc_redir)
    else $error("machine trap touched supervisor redirect");
  a_nmi_wakes: assert property (sleeping && nmi_req |=> !sleeping)
    else $error("nmi did not wake");
  c_s_trap: cover property (trap_take && trap_to_s && !trap_is_irq);
  c_s_irq: cover property (trap_take && trap_to_s && trap_is_irq);
  c_sleep: cover property ($fell(sleeping));
endmodule // tetc_trap_chk

bind tetc_trap_ctl tetc_trap_chk tetc_trap_chk_i (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .exc_vec,
  .irq_vld, .nmi_req, .sret_req, .mret_req, .irq_active_m, .trap_take, .trap_to_s, .trap_is_irq, .pc_redir,
  .sleeping, .prv_mode);

// File: tetc_irq_src.sv
// Model of the interrupt arbiter ahead of the trap block: two candidates.
// Assumes keys pack mode, level and priority with mode in the top two bits.
`timescale 1ns/1ps
module tetc_irq_src (
  input  wire [1:0]  cand_en,
  input  wire [15:0] cand_key0,
  input  wire [15:0] cand_key1,
  output reg  [15:0] irq_vld,
  output reg  [15:0] irq_key,
  output reg  [7:0]  irq_id
);
  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // Mode on top makes any machine candidate beat any supervisor one
  always @* begin
    irq_vld = {15'h0, |cand_en};
    irq_key = 16'h0;
    irq_id = 8'h0;
    if (cand_en[0]) begin
      irq_key = cand_key0;
      irq_id = 8'h10;
    end
    if (cand_en[1] && (!cand_en[0] || cand_key1 > cand_key0)) begin
      irq_key = cand_key1;
      irq_id = 8'h11;
    end
  end
endmodule // tetc_irq_src

// File: test_tee_trap_and_wfi_control.sv
// Self-checking bench for the trap and wait control block.
// Assumes the checker is bound by its own file and a 50 ns clock.
`timescale 1ns/1ps
`include "tetc_defines.vh"
module test_tee_trap_and_wfi_control;
  reg         clk, sys_rst, cyc, stb, we, sret, mret, act_m, nmi, dbg, wfi, wfe, evt, tv_vld;
  reg  [7:0]  adr;
  reg  [31:0] wdat, pc, pc0, tval, vec, q;
  reg  [15:0] exc, k0, k1, ivld, ikey;
  reg  [1:0]  mprv, c_en;
  wire [7:0]  iid;
  wire [31:0] wb_dat_o, trap_cause, pc_target;
  wire        wb_ack_o, trap_take, trap_to_s, trap_is_irq, pc_redir, sleeping, wake;
  wire [1:0]  prv_mode;
  integer     miscompares, checked, seed, cyc_n;
  reg         got_t, got_s, got_w;
  tetc_irq_src tetc_irq_src_i (.cand_en(c_en), .cand_key0(k0), .cand_key1(k1), .irq_vld(ivld), .irq_key(ikey),
    .irq_id(iid));
  tetc_trap_ctl tetc_trap_ctl_i (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cur_pc(pc),
    .exc_vec(exc), .exc_tval(tval), .exc_tval_vld(tv_vld), .sret_req(sret), .mret_req(mret), .mret_prv(mprv),
    .irq_vld(ivld), .irq_key(ikey), .irq_id(iid), .irq_active_m(act_m), .nmi_req(nmi), .dbg_req(dbg),
    .wfi_req(wfi), .wfe_sel(wfe), .event_req(evt), .trap_take(trap_take), .trap_to_s(trap_to_s),
    .trap_cause(trap_cause), .trap_is_irq(trap_is_irq), .pc_redir(pc_redir), .pc_target(pc_target),
    .sleeping(sleeping), .wake(wake), .prv_mode(prv_mode));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    @(posedge clk);
    while (wb_ack_o !== 1'b1) @(posedge clk);
    q = wb_dat_o;
    {cyc, stb, we} <= 3'h0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task pulse_exc(input logic [15:0] v);
    @(posedge clk) exc <= v;
    @(posedge clk) exc <= 16'h0;
    #1;
  endtask
  task ret(input logic m, input logic [1:0] p);
    @(posedge clk) {mret, sret, mprv} <= {m, !m, p};
    @(posedge clk) {mret, sret} <= 2'b00;
    #1;
  endtask
  task nap(input logic w);
    @(posedge clk) {wfi, wfe} <= {1'b1, w};
    @(posedge clk) wfi <= 1'b0;
    #1 chk(32'(sleeping), 32'h1);
  endtask
  task watch;
    {got_t, got_s, got_w} = 3'b000;
    repeat (4) begin
      @(posedge clk);
      #1 {got_t, got_s, got_w} = {got_t, got_s, got_w} | {trap_take, trap_take & trap_to_s & trap_is_irq, wake};
    end
  endtask
  always @(posedge clk) begin
    cyc_n = cyc_n + 1;
    if (cyc_n == 3000) begin
      miscompares = miscompares + 1;
      summarize;
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {cyc, stb, we, sret, mret, act_m, nmi, dbg, wfi, wfe, evt, tv_vld, sys_rst} = 13'h1;
    {adr, wdat, exc, mprv, c_en} = 0;
    {miscompares, checked, cyc_n} = 0;
    seed = 44222;
    pc = $random(seed);
    tval = $random(seed);
    vec = $random(seed) & 32'hfffffffc;
    k0 = {2'h1, 14'($random(seed))};
    k1 = {2'h3, 14'($random(seed))};
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`TETC_OFF_SSTATUS, 32'h20);
    wb(1'b1, 8'h24, vec);
    rd(8'h24, 32'h0);
    wb(1'b1, `TETC_OFF_STVEC, vec);
    wb(1'b1, `TETC_OFF_MEDELEG, 32'h4);
    chk(32'(prv_mode), 32'h3);
    pulse_exc(16'h4);
    chk({trap_take, trap_to_s, trap_cause[29:0]}, 32'h80000002);
    ret(1'b1, 2'h0);
    pulse_exc(16'h20 | 16'($random(seed)) & 16'hffc0);
    chk({trap_take, trap_to_s, trap_cause[29:0]}, 32'hc0000005);
    chk(pc_target, vec);
    pc0 = pc;
    @(posedge clk) pc <= $random(seed);
    rd(`TETC_OFF_SEPC, pc0);
    rd(`TETC_OFF_STVAL, 32'h0);
    rd(`TETC_OFF_SSTATUS, 32'h0);
    pulse_exc(16'h24);
    chk({trap_take, trap_to_s, trap_cause[29:0]}, 32'h80000005);
    rd(`TETC_OFF_SEPC, pc0);
    ret(1'b1, 2'h1);
    ret(1'b0, 2'h0);
    chk(pc_target, pc0);
    rd(`TETC_OFF_SSTATUS, 32'h20);
    @(posedge clk) nmi <= 1'b1;
    @(posedge clk) nmi <= 1'b0;
    #1 chk({trap_take, trap_to_s, trap_cause[29:0]}, 32'h80000000);
    ret(1'b1, 2'h1);
    @(posedge clk) tv_vld <= 1'b1;
    pulse_exc(16'h4);
    chk(32'(trap_to_s), 32'h1);
    rd(`TETC_OFF_STVAL, tval);
    nap(1'b0);
    @(posedge clk) c_en <= 2'b01;
    watch;
    chk({got_w, got_t}, 32'h2);
    @(posedge clk) c_en <= 2'b10;
    watch;
    chk(32'(prv_mode), 32'h3);
    @(posedge clk) c_en <= 2'b00;
    ret(1'b1, 2'h1);
    ret(1'b0, 2'h0);
    chk(pc_target, pc);
    rd(`TETC_OFF_SSTATUS, 32'h20);
    nap(1'b0);
    @(posedge clk) c_en <= 2'b01;
    watch;
    chk(32'(got_s), 32'h1);
    rd(`TETC_OFF_SCAUSE, 32'h80000010);
    @(posedge clk) c_en <= 2'b00;
    pulse_exc(16'h20);
    @(posedge clk) {act_m, c_en} <= 3'b101;
    watch;
    chk(32'(got_t), 32'h0);
    nap(1'b0);
    watch;
    chk(32'(sleeping), 32'h1);
    @(posedge clk) c_en <= 2'b11;
    watch;
    chk({got_w, got_t}, 32'h2);
    @(posedge clk) c_en <= 2'b00;
    wb(1'b1, `TETC_OFF_MSTATUS, 32'h8);
    nap(1'b0);
    @(posedge clk) c_en <= 2'b11;
    watch;
    chk({got_w, got_t}, 32'h3);
    wb(1'b1, `TETC_OFF_MSTATUS, 32'h0);
    nap(1'b1);
    watch;
    chk(32'(sleeping), 32'h1);
    @(posedge clk) evt <= 1'b1;
    watch;
    chk(32'(got_w), 32'h1);
    @(posedge clk) {evt, c_en, act_m} <= 4'h0;
    nap(1'b0);
    @(posedge clk) nmi <= 1'b1;
    watch;
    chk(32'(got_w), 32'h1);
    @(posedge clk) nmi <= 1'b0;
    nap(1'b0);
    @(posedge clk) dbg <= 1'b1;
    watch;
    chk(32'(got_w), 32'h1);
    summarize;
  end
endmodule // test_tee_trap_and_wfi_control
